// ===== core/dsq_sequencer_ctl.sv
`timescale 1ns/1ns
// Function
// - early bit clear extends read gate through checksum
// - select bits choose index/sector event edges
// - read compare bit switches buffer to reading
// - abort bit stops command within three bytes
// - checksum error flag, forced zero when ignored
// - id crc flag latches, clears on read start
// - parity error flags, halts at instruction end
// - sync search failure sets sync flag
// - field mismatch sets compare flag
// - reset leaves both registers unchanged
// - start write loads holding register and counter
// - sector count write when stopped starts at hold
// - start read returns live address counter
// - store window write increments counter
// - start write clears all latched error flags
// - start write with sectors left starts running
// - skip instruction end loads skip address
// - jump loads loop if sectors, else increments
// - retry with checksum, sync or compare flag loads loop address
// - restart after stop uses holding register
// - otherwise counter increments sequentially
// - halt on read error keeps error status
// - any non-zero sector count starts sequencer
// - parity disable zeroes flag, no parity halt
module dsq_sequencer_ctl
    import dsq_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic index_pin,
    input wire logic sector_pin,
    input wire logic [7:0] sector_count,
    input wire logic sector_count_write,
    input wire logic store_window_write,
    input wire logic [DSQ_PC_W-1:0] skip_address,
    input wire logic [DSQ_PC_W-1:0] loop_address,
    input wire dsq_instr_t instr,
    input wire dsq_err_evt_t err_evt,
    input wire logic id_field_read,
    input wire logic read_gate_request,
    input wire logic checksum_busy,
    input wire logic write_gate_request,
    output logic read_gate,
    output logic write_gate,
    output logic buffer_read_select,
    output logic sector_or_index_event,
    output logic command_abort,
    output logic sequencer_running,
    output logic sequencer_start,
    output logic clear_error_flags,
    output logic [DSQ_PC_W-1:0] store_address
);

    dsq_state_t r_reg;
    dsq_state_t r_next;

    logic wr_fire;
    logic wr_ctl;
    logic wr_start;
    logic wr_opt;
    logic wr_known;
    logic [7:0] rd_addr;
    logic [7:0] ctl_status;
    logic parity_halt;
    logic read_err_halt;
    logic retry_now;
    logic restart;

    // write is carried out once address and data are both held
    assign wr_fire = r_reg.aw_got && r_reg.w_got && !r_reg.bvalid;
    assign wr_ctl = wr_fire && r_reg.w_lane0 && (r_reg.aw_addr == DSQ_ADDR_CONTROL_STATUS);
    assign wr_start = wr_fire && r_reg.w_lane0 && (r_reg.aw_addr == DSQ_ADDR_START_ADDRESS);
    assign wr_opt = wr_fire && r_reg.w_lane0 && (r_reg.aw_addr == DSQ_ADDR_OPTIONS);
    assign wr_known = (r_reg.aw_addr == DSQ_ADDR_CONTROL_STATUS) ||
                      (r_reg.aw_addr == DSQ_ADDR_START_ADDRESS) || (r_reg.aw_addr == DSQ_ADDR_OPTIONS);
    assign rd_addr = s_axi_araddr;

    // status byte as software sees it
    always_comb
    begin
        ctl_status = 8'h00;
        ctl_status[DSQ_BIT_CHECKSUM_ERR] = r_reg.err.checksum && !r_reg.ignore_checksum;
        ctl_status[DSQ_BIT_ID_CRC_ERR] = r_reg.err.id_crc;
        ctl_status[DSQ_BIT_PARITY_ERR] = r_reg.err.parity && !r_reg.parity_disable;
        ctl_status[DSQ_BIT_SYNC_ERR] = r_reg.err.sync;
        ctl_status[DSQ_BIT_COMPARE_ERR] = r_reg.err.compare;
    end

    // error conditions tested at instruction end
    assign parity_halt = r_reg.err.parity && !r_reg.parity_disable;
    assign read_err_halt = (r_reg.err.checksum && !r_reg.ignore_checksum) || r_reg.err.sync ||
                           r_reg.err.compare;
    assign retry_now = instr.retry_enable && read_err_halt;
    assign restart = sector_count_write && (sector_count != DSQ_SECTOR_ZERO) &&
                     (r_reg.seq == DSQ_SEQ_STOPPED);

    // next-state logic for the whole block
    always_comb
    begin
        r_next = r_reg;
        r_next.event_pulse = 1'b0;
        r_next.start_pulse = 1'b0;
        r_next.clear_pulse = 1'b0;

        // pin synchronisers; a level counts once stages two and three agree
        r_next.index_sync = {r_reg.index_sync[1:0], index_pin};
        r_next.sector_sync = {r_reg.sector_sync[1:0], sector_pin};
        if (r_reg.index_sync[1] == r_reg.index_sync[2])
        begin
            r_next.index_level = r_reg.index_sync[2];
        end
        if (r_reg.sector_sync[1] == r_reg.sector_sync[2])
        begin
            r_next.sector_level = r_reg.sector_sync[2];
        end
        // leading edges gated by the source selects only
        r_next.event_pulse = (r_reg.index_select && r_next.index_level && !r_reg.index_level) ||
                             (r_reg.sector_select && r_next.sector_level && !r_reg.sector_level);

        // control/status write bits
        if (wr_ctl)
        begin
            r_next.read_gate_early = r_reg.w_data[DSQ_BIT_READ_GATE_EARLY];
            r_next.index_select = r_reg.w_data[DSQ_BIT_INDEX_SELECT];
            r_next.sector_select = r_reg.w_data[DSQ_BIT_SECTOR_SELECT];
            r_next.read_compare = r_reg.w_data[DSQ_BIT_READ_COMPARE];
            r_next.abort = r_reg.w_data[DSQ_BIT_ABORT];
        end
        if (wr_opt)
        begin
            r_next.ignore_checksum = r_reg.w_data[DSQ_BIT_IGNORE_CHECKSUM];
            r_next.parity_disable = r_reg.w_data[DSQ_BIT_PARITY_DISABLE];
        end

        // start write clears flags; events in the same cycle still set them
        if (wr_start)
        begin
            r_next.err = '0;
            r_next.clear_pulse = 1'b1;
        end
        // id flag clears when an id field read begins
        r_next.id_read_q = id_field_read;
        if (id_field_read && !r_reg.id_read_q)
        begin
            r_next.err.id_crc = 1'b0;
        end
        if (err_evt.checksum && !r_reg.ignore_checksum)
        begin
            r_next.err.checksum = 1'b1;
        end
        if (err_evt.id_retry)
        begin
            r_next.err.id_crc = 1'b1;
        end
        if (err_evt.parity && !r_reg.parity_disable)
        begin
            r_next.err.parity = 1'b1;
        end
        if (err_evt.sync)
        begin
            r_next.err.sync = 1'b1;
        end
        if (err_evt.compare)
        begin
            r_next.err.compare = 1'b1;
        end

        // program counter and run state
        if (r_reg.seq == DSQ_SEQ_RUNNING && instr.done)
        begin
            if (retry_now)
            begin
                r_next.pc = loop_address;
            end
            else if ((instr.halt_on_error && (read_err_halt || parity_halt)) || instr.stop)
            begin
                r_next.seq = DSQ_SEQ_STOPPED;
            end
            else if (instr.jump_enable)
            begin
                r_next.pc = (sector_count != DSQ_SECTOR_ZERO) ? loop_address : r_reg.pc + DSQ_PC_ONE;
            end
            else if (instr.skip_enable)
            begin
                r_next.pc = skip_address;
            end
            else
            begin
                r_next.pc = r_reg.pc + DSQ_PC_ONE;
            end
        end
        if (store_window_write)
        begin
            r_next.pc = r_reg.pc + DSQ_PC_ONE;
        end
        if (restart)
        begin
            r_next.pc = r_reg.hold;
            r_next.seq = DSQ_SEQ_RUNNING;
            r_next.start_pulse = 1'b1;
        end
        if (wr_start)
        begin
            r_next.hold = r_reg.w_data[DSQ_PC_W-1:0];
            r_next.pc = r_reg.w_data[DSQ_PC_W-1:0];
            if (sector_count != DSQ_SECTOR_ZERO)
            begin
                r_next.seq = DSQ_SEQ_RUNNING;
                r_next.start_pulse = 1'b1;
            end
        end
        if (r_reg.abort)
        begin
            r_next.seq = DSQ_SEQ_STOPPED;
            r_next.start_pulse = 1'b0;
        end

        // gates to the drive; read gate stretched while checksum runs
        r_next.read_gate = read_gate_request || (!r_reg.read_gate_early && checksum_busy);
        r_next.write_gate = write_gate_request && (r_next.seq == DSQ_SEQ_RUNNING);

        // write channels taken in either order
        if (s_axi_awvalid && r_reg.awready)
        begin
            r_next.aw_got = 1'b1;
            r_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && r_reg.wready)
        begin
            r_next.w_got = 1'b1;
            r_next.w_data = s_axi_wdata[7:0];
            r_next.w_lane0 = s_axi_wstrb[0];
        end
        if (wr_fire)
        begin
            r_next.bvalid = 1'b1;
            r_next.bresp = wr_known ? DSQ_RESP_OKAY : DSQ_RESP_SLVERR;
            r_next.aw_got = 1'b0;
            r_next.w_got = 1'b0;
        end
        if (r_reg.bvalid && s_axi_bready)
        begin
            r_next.bvalid = 1'b0;
        end
        r_next.awready = !r_next.aw_got && !r_next.bvalid && !wr_fire;
        r_next.wready = !r_next.w_got && !r_next.bvalid && !wr_fire;

        // read channel; start read returns the live counter
        if (s_axi_arvalid && r_reg.arready)
        begin
            r_next.rvalid = 1'b1;
            r_next.rresp = DSQ_RESP_OKAY;
            unique case (rd_addr)
                DSQ_ADDR_CONTROL_STATUS: r_next.rdata = ctl_status;
                DSQ_ADDR_START_ADDRESS: r_next.rdata = {3'h0, r_reg.pc};
                DSQ_ADDR_OPTIONS: r_next.rdata = {(r_reg.seq == DSQ_SEQ_RUNNING), 5'h00,
                                                  r_reg.parity_disable, r_reg.ignore_checksum};
                default:
                begin
                    r_next.rdata = 8'h00;
                    r_next.rresp = DSQ_RESP_SLVERR;
                end
            endcase
        end
        if (r_reg.rvalid && s_axi_rready)
        begin
            r_next.rvalid = 1'b0;
        end
        r_next.arready = !r_next.rvalid && !(s_axi_arvalid && r_reg.arready);
    end

    // state register; reset spares the two software registers
    always_ff @(posedge aclk)
    begin
        r_reg <= r_next;
        if (!aresetn)
        begin
            r_reg.seq <= DSQ_SEQ_STOPPED;
            r_reg.index_sync <= 3'h0;
            r_reg.sector_sync <= 3'h0;
            r_reg.index_level <= 1'b0;
            r_reg.sector_level <= 1'b0;
            r_reg.id_read_q <= 1'b0;
            r_reg.event_pulse <= 1'b0;
            r_reg.start_pulse <= 1'b0;
            r_reg.clear_pulse <= 1'b0;
            r_reg.read_gate <= 1'b0;
            r_reg.write_gate <= 1'b0;
            r_reg.ignore_checksum <= 1'b0;
            r_reg.parity_disable <= 1'b0;
            r_reg.aw_got <= 1'b0;
            r_reg.aw_addr <= 8'h00;
            r_reg.w_got <= 1'b0;
            r_reg.w_data <= 8'h00;
            r_reg.w_lane0 <= 1'b0;
            r_reg.awready <= 1'b0;
            r_reg.wready <= 1'b0;
            r_reg.bvalid <= 1'b0;
            r_reg.bresp <= DSQ_RESP_OKAY;
            r_reg.arready <= 1'b0;
            r_reg.rvalid <= 1'b0;
            r_reg.rdata <= 8'h00;
            r_reg.rresp <= DSQ_RESP_OKAY;
        end
    end

    // outputs straight from the state register
    assign s_axi_awready = r_reg.awready;
    assign s_axi_wready = r_reg.wready;
    assign s_axi_bvalid = r_reg.bvalid;
    assign s_axi_bresp = r_reg.bresp;
    assign s_axi_arready = r_reg.arready;
    assign s_axi_rvalid = r_reg.rvalid;
    assign s_axi_rdata = {24'h000000, r_reg.rdata};
    assign s_axi_rresp = r_reg.rresp;
    assign read_gate = r_reg.read_gate;
    assign write_gate = r_reg.write_gate;
    assign buffer_read_select = r_reg.read_compare;
    assign sector_or_index_event = r_reg.event_pulse;
    assign command_abort = r_reg.abort;
    assign sequencer_running = (r_reg.seq == DSQ_SEQ_RUNNING);
    assign sequencer_start = r_reg.start_pulse;
    assign clear_error_flags = r_reg.clear_pulse;
    assign store_address = r_reg.pc;

endmodule : dsq_sequencer_ctl

// ===== core/dsq_pkg.sv
package dsq_pkg;

    // register indices as printed; byte address is four times the index
    localparam logic [7:0] DSQ_IDX_CONTROL_STATUS = 8'h0B;
    localparam logic [7:0] DSQ_IDX_START_ADDRESS = 8'h0C;
    localparam logic [7:0] DSQ_IDX_OPTIONS = 8'h10;
    localparam logic [7:0] DSQ_ADDR_CONTROL_STATUS = 8'h2C;
    localparam logic [7:0] DSQ_ADDR_START_ADDRESS = 8'h30;
    localparam logic [7:0] DSQ_ADDR_OPTIONS = 8'h40;

    // control/status write fields
    localparam int DSQ_BIT_READ_GATE_EARLY = 7;
    localparam int DSQ_BIT_INDEX_SELECT = 3;
    localparam int DSQ_BIT_SECTOR_SELECT = 2;
    localparam int DSQ_BIT_READ_COMPARE = 1;
    localparam int DSQ_BIT_ABORT = 0;
    // control/status read fields
    localparam int DSQ_BIT_CHECKSUM_ERR = 5;
    localparam int DSQ_BIT_ID_CRC_ERR = 4;
    localparam int DSQ_BIT_PARITY_ERR = 3;
    localparam int DSQ_BIT_SYNC_ERR = 2;
    localparam int DSQ_BIT_COMPARE_ERR = 1;
    // options register fields
    localparam int DSQ_BIT_IGNORE_CHECKSUM = 0;
    localparam int DSQ_BIT_PARITY_DISABLE = 1;
    localparam int DSQ_BIT_RUNNING = 7;

    localparam int DSQ_PC_W = 5;
    localparam logic [DSQ_PC_W-1:0] DSQ_PC_ONE = 5'h01;
    localparam logic [7:0] DSQ_SECTOR_ZERO = 8'h00;
    localparam logic [1:0] DSQ_RESP_OKAY = 2'h0;
    localparam logic [1:0] DSQ_RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        DSQ_SEQ_STOPPED = 2'b01,
        DSQ_SEQ_RUNNING = 2'b10
    } dsq_seq_t;

    // instruction-end information from the control store decoder
    typedef struct packed {
        logic done;
        logic skip_enable;
        logic jump_enable;
        logic retry_enable;
        logic halt_on_error;
        logic stop;
    } dsq_instr_t;

    // one-cycle error events from the data path
    typedef struct packed {
        logic checksum;
        logic id_retry;
        logic parity;
        logic sync;
        logic compare;
    } dsq_err_evt_t;

    // latched error flags
    typedef struct packed {
        logic checksum;
        logic id_crc;
        logic parity;
        logic sync;
        logic compare;
    } dsq_err_t;

    typedef struct packed {
        dsq_seq_t seq;
        logic read_gate_early;
        logic index_select;
        logic sector_select;
        logic read_compare;
        logic abort;
        dsq_err_t err;
        logic ignore_checksum;
        logic parity_disable;
        logic [DSQ_PC_W-1:0] hold;
        logic [DSQ_PC_W-1:0] pc;
        logic [2:0] index_sync;
        logic [2:0] sector_sync;
        logic index_level;
        logic sector_level;
        logic id_read_q;
        logic event_pulse;
        logic start_pulse;
        logic clear_pulse;
        logic read_gate;
        logic write_gate;
        logic aw_got;
        logic [7:0] aw_addr;
        logic w_got;
        logic [7:0] w_data;
        logic w_lane0;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
    } dsq_state_t;

endpackage : dsq_pkg

// ===== verif/dsq_checker.sv
`timescale 1ns/1ns
module dsq_checker
    import dsq_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_bvalid,
    input wire logic [7:0] sector_count,
    input wire logic sector_count_write,
    input wire logic store_window_write,
    input wire logic [DSQ_PC_W-1:0] skip_address,
    input wire logic [DSQ_PC_W-1:0] loop_address,
    input wire dsq_instr_t instr,
    input wire logic read_gate_request,
    input wire logic read_gate,
    input wire logic write_gate,
    input wire logic sector_or_index_event,
    input wire logic command_abort,
    input wire logic sequencer_running,
    input wire logic sequencer_start,
    input wire logic clear_error_flags,
    input wire logic [DSQ_PC_W-1:0] store_address
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic end_ok;

    // plain instruction end with no competing counter event
    assign end_ok = instr.done && sequencer_running && !store_window_write && !sector_count_write
        && !command_abort && !instr.stop && !instr.halt_on_error && !instr.retry_enable;

    a_abort_stops: assert property (command_abort |=> !sequencer_running)
        else $error("abort left the sequencer running");
    a_gate_follows: assert property (read_gate_request |=> read_gate)
        else $error("read gate missing after request");
    a_write_gate_run: assert property (write_gate |-> sequencer_running)
        else $error("write gate while stopped");
    a_run_start: assert property ($rose(sequencer_running) |-> sequencer_start)
        else $error("run began without start pulse");
    a_count_starts: assert property (sector_count_write && sector_count != DSQ_SECTOR_ZERO
        && !sequencer_running && !command_abort |=> sequencer_running)
        else $error("non-zero sector count did not start");
    a_clear_pulse: assert property (clear_error_flags |-> s_axi_bvalid ##1 !clear_error_flags)
        else $error("error clear pulse misplaced");
    a_window_step: assert property (store_window_write && !sector_count_write && !command_abort
        |=> s_axi_bvalid || store_address == $past(store_address) + DSQ_PC_ONE)
        else $error("window write did not step the counter");
    a_skip_load: assert property (end_ok && instr.skip_enable && !instr.jump_enable
        |=> s_axi_bvalid || store_address == $past(skip_address))
        else $error("skip address not loaded");
    a_jump_load: assert property (end_ok && instr.jump_enable && sector_count != DSQ_SECTOR_ZERO
        |=> s_axi_bvalid || store_address == $past(loop_address))
        else $error("loop address not loaded");
    a_step_next: assert property (end_ok && !instr.skip_enable
        && (!instr.jump_enable || sector_count == DSQ_SECTOR_ZERO)
        |=> s_axi_bvalid || store_address == $past(store_address) + DSQ_PC_ONE)
        else $error("counter did not step");
    a_event_pulse: assert property (sector_or_index_event |=> !sector_or_index_event)
        else $error("event longer than one cycle");

    // main scenarios reached
    c_start: cover property (sequencer_start);
    c_retry: cover property (instr.done && instr.retry_enable);
    c_event: cover property (sector_or_index_event);
    c_wg_drop: cover property (write_gate ##1 !write_gate);
endmodule : dsq_checker

bind dsq_sequencer_ctl dsq_checker i_chk (.*);

// ===== verif/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    import dsq_pkg::*;
    localparam logic [7:0] ctl_a = DSQ_ADDR_CONTROL_STATUS;
    localparam logic [7:0] st_a = DSQ_ADDR_START_ADDRESS;
    localparam logic [7:0] opt_a = DSQ_ADDR_OPTIONS;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, sector_count = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_bready = 1'b1, s_axi_rready = 1'b1, started = 1'b0, cleared = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic index_pin = 1'b0, sector_pin = 1'b0, sector_count_write = 1'b0, store_window_write = 1'b0;
    logic id_field_read = 1'b0, read_gate_request = 1'b0, checksum_busy = 1'b0, write_gate_request = 1'b0;
    logic [DSQ_PC_W-1:0] skip_address = 5'h09, loop_address = 5'h11, store_address;
    dsq_instr_t instr = '0;
    dsq_err_evt_t err_evt = '0;
    logic read_gate, write_gate, buffer_read_select, sector_or_index_event, command_abort;
    logic sequencer_running, sequencer_start, clear_error_flags;
    int error_cnt = 0, total_checks = 0, cyc = 0, ev_cnt = 0, e0, s;

    dsq_sequencer_ctl i_dut (.*);

    // clock
    always #50 aclk = ~aclk;

    // watchdog and event tallies
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (sector_or_index_event) ev_cnt <= ev_cnt + 1;
        if (sequencer_start) started <= 1'b1;
        if (clear_error_flags) cleared <= 1'b1;
        if (cyc == 20000)
        begin
            error_cnt++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic pa, pw, ha, hw, done;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        pa = 1'b1;
        pw = 1'b1;
        done = 1'b0;
        while (!done)
        begin
            @(negedge aclk);
            ha = pa && s_axi_awready;
            hw = pw && s_axi_wready;
            done = s_axi_bvalid;
            rsp = s_axi_bresp;
            @(posedge aclk);
            if (ha) s_axi_awvalid <= 1'b0;
            if (hw) s_axi_wvalid <= 1'b0;
            pa = pa && !ha;
            pw = pw && !hw;
        end
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a);
        logic pa, ha, done;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        pa = 1'b1;
        done = 1'b0;
        while (!done)
        begin
            @(negedge aclk);
            ha = pa && s_axi_arready;
            done = s_axi_rvalid;
            rd = s_axi_rdata;
            rsp = s_axi_rresp;
            @(posedge aclk);
            if (ha) s_axi_arvalid <= 1'b0;
            pa = pa && !ha;
        end
    endtask : axi_rd

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        axi_rd(a);
        chk(rd, exp);
    endtask : rd_chk

    task automatic evt(input dsq_err_evt_t v);
        @(posedge aclk);
        err_evt <= v;
        @(posedge aclk);
        err_evt <= '0;
    endtask : evt

    task automatic iend(input dsq_instr_t v);
        @(posedge aclk);
        instr <= v;
        @(posedge aclk);
        instr <= '0;
        @(negedge aclk);
    endtask : iend

    task automatic scw(input logic [7:0] n);
        @(posedge aclk);
        sector_count <= n;
        sector_count_write <= 1'b1;
        @(posedge aclk);
        sector_count_write <= 1'b0;
        @(posedge aclk);
        @(negedge aclk);
    endtask : scw

    task automatic pins(input logic [1:0] v);
        @(posedge aclk);
        {index_pin, sector_pin} <= v;
        repeat (5) @(posedge aclk);
        {index_pin, sector_pin} <= 2'b00;
        repeat (5) @(posedge aclk);
    endtask : pins

    // main sequence
    initial
    begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        axi_wr(ctl_a, 32'h0);
        chk(32'(rsp), 32'(DSQ_RESP_OKAY));
        axi_wr(8'h04, 32'h0);
        chk(32'(rsp), 32'(DSQ_RESP_SLVERR));
        axi_wr(opt_a, 32'h0);
        axi_wr(st_a, 32'h03);
        rd_chk(st_a, 32'h03);
        chk(32'(cleared), 32'h1);
        rd_chk(ctl_a, 32'h0);
        axi_rd(8'h04);
        chk(32'(rsp), 32'(DSQ_RESP_SLVERR));
        // every error source latched, id flag cleared by id read
        evt(5'b11111);
        rd_chk(ctl_a, 32'h3E);
        @(posedge aclk);
        id_field_read <= 1'b1;
        @(posedge aclk);
        id_field_read <= 1'b0;
        rd_chk(ctl_a, 32'h2E);
        axi_wr(st_a, 32'h03);
        rd_chk(ctl_a, 32'h0);
        axi_wr(opt_a, 32'h03);
        evt(5'b10100);
        rd_chk(ctl_a, 32'h0);
        axi_wr(opt_a, 32'h0);
        @(posedge aclk);
        store_window_write <= 1'b1;
        @(posedge aclk);
        store_window_write <= 1'b0;
        rd_chk(st_a, 32'h04);
        // program flow
        scw(8'h02);
        chk(32'(started), 32'h1);
        chk(32'(store_address), 32'h03);
        iend(6'b100000);
        chk(32'(store_address), 32'h04);
        iend(6'b110000);
        chk(32'(store_address), 32'h09);
        iend(6'b101000);
        chk(32'(store_address), 32'h11);
        @(posedge aclk);
        sector_count <= 8'h00;
        iend(6'b101000);
        chk(32'(store_address), 32'h12);
        evt(5'b00010);
        iend(6'b111100);
        chk(32'(store_address), 32'h11);
        iend(6'b100001);
        chk(32'(sequencer_running), 32'h0);
        rd_chk(st_a, 32'h11);
        scw(8'h01);
        chk(32'(store_address), 32'h03);
        // halt on parity error, sync flag still latched
        @(posedge aclk);
        write_gate_request <= 1'b1;
        @(negedge aclk);
        @(negedge aclk);
        chk(32'(write_gate), 32'h1);
        evt(5'b00100);
        iend(6'b100010);
        chk(32'(write_gate), 32'h0);
        chk(32'(store_address), 32'h03);
        rd_chk(ctl_a, 32'h0C);
        @(posedge aclk);
        write_gate_request <= 1'b0;
        axi_wr(st_a, 32'h05);
        chk(32'(sequencer_running), 32'h1);
        rd_chk(ctl_a, 32'h0);
        // abort, held for two byte times
        axi_wr(ctl_a, 32'h01);
        @(negedge aclk);
        chk(32'(command_abort), 32'h1);
        chk(32'(sequencer_running), 32'h0);
        repeat (2) @(posedge aclk);
        axi_wr(ctl_a, 32'h02);
        @(negedge aclk);
        chk(32'(buffer_read_select), 32'h1);
        // read gate extension
        axi_wr(ctl_a, 32'h0);
        @(posedge aclk);
        checksum_busy <= 1'b1;
        @(negedge aclk);
        @(negedge aclk);
        chk(32'(read_gate), 32'h1);
        axi_wr(ctl_a, 32'h80);
        @(negedge aclk);
        @(negedge aclk);
        chk(32'(read_gate), 32'h0);
        @(posedge aclk);
        checksum_busy <= 1'b0;
        // event source selection
        for (s = 0; s < 4; s++)
        begin
            axi_wr(ctl_a, 32'(s) << 2);
            e0 = ev_cnt;
            pins(2'b10);
            pins(2'b01);
            chk(32'(ev_cnt - e0), 32'(s[0]) + 32'(s[1]));
        end
        // registers survive reset
        @(posedge aclk);
        sector_count <= 8'h00;
        axi_wr(st_a, 32'h07);
        axi_wr(ctl_a, 32'h02);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd_chk(st_a, 32'h07);
        chk(32'(buffer_read_select), 32'h1);
        stop_test();
    end
endmodule : tb_top
